//--- ivsd_pkg.sv
package ivsd_pkg;
  // channel organisation
  localparam int NUM_CH        = 16;
  localparam int GRP_SIZE      = 4;
  localparam int NUM_GRP       = 4;
  // process image word addresses (byte addresses, words of two bytes)
  localparam logic [7:0] ADDR_INPUT_WORD  = 8'h00;
  localparam logic [7:0] ADDR_STATUS_OFS  = 8'h02;
  // diagnostic records
  localparam int REC0_LEN      = 4;
  localparam int REC1_LEN      = 8;
  localparam logic [1:0] REC_SEL_0 = 2'h0;
  localparam logic [1:0] REC_SEL_1 = 2'h1;
  // common header byte 0 bit positions
  localparam int HDR_MOD_FAULT = 0;
  localparam int HDR_INT_FAULT = 1;
  localparam int HDR_EXT_FAULT = 2;
  localparam int HDR_CH_FAULT  = 3;
  localparam int HDR_NO_PWR    = 4;
  // header byte 1: module class code for digital input
  localparam logic [7:0] HDR_CLASS_DI = 8'h0F;
  // header byte 2 / 3 reset values
  localparam logic [7:0] HDR_BYTE2_RST = 8'h00;
  localparam logic [7:0] HDR_BYTE3_RST = 8'h00;
  // validity encoding
  localparam logic VALID_YES = 1'b1;
  localparam logic VALID_NO  = 1'b0;
  // record read states
  typedef enum logic [1:0] {
    IVSD_IDLE = 2'b00,
    IVSD_SEND = 2'b01,
    IVSD_DONE = 2'b10
  } ivsd_state_t;
endpackage

//--- ivsd_rec_mem.sv
`timescale 1ns/100ps
`default_nettype none
// small byte memory holding a diagnostic record, registered read data
module ivsd_rec_mem #(
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     sys_rst,
  // write side
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [7:0]               wr_data,
  // read side
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [7:0]               rd_data
);
  logic [7:0] mem_reg [DEPTH];

  // storage, no reset on array
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  // registered read port
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem_reg[rd_addr];
    end
  end
endmodule
`default_nettype wire

//--- ivsd_top.sv
// How it works
// - validity bit written in the same update as its input value
// - status word for input word x is placed at address x+2
// - validity is 0 for invalid signal, 1 for valid signal
// - sensor/power fail, wire break, short, flutter, changeover fault clear validity
// - record 0 is a 4-byte common header with current overall status
// - record 1 repeats the 4 header bytes then module-specific bytes
// - a diagnostic bit is 1 while its error is present
// - supply fault in a group of four sets error bits of all four channels
// - header bytes 0 to 3 use the common layout for all module types
`timescale 1ns/100ps
`default_nettype none
module ivsd_top #(
  parameter int NUM_CH = ivsd_pkg::NUM_CH
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  // per-channel field inputs and fault detectors
  input  wire logic [NUM_CH-1:0] din_value,
  input  wire logic [NUM_CH-1:0] flt_wire_break,
  input  wire logic [NUM_CH-1:0] flt_short,
  input  wire logic [NUM_CH-1:0] flt_flutter,
  input  wire logic [NUM_CH-1:0] flt_changeover,
  input  wire logic [3:0]        flt_supply,
  input  wire logic              flt_internal,
  input  wire logic              flt_no_power,
  // sample strobe: update the process image
  input  wire logic              sample_en,
  // process image read port
  input  wire logic              img_rd,
  input  wire logic [7:0]        img_addr,
  output logic      [15:0]       img_data,
  output logic                   img_valid,
  // diagnostic record read port
  input  wire logic              rec_start,
  input  wire logic [1:0]        rec_sel,
  output logic      [7:0]        rec_data,
  output logic                   rec_valid,
  output logic                   rec_last,
  output logic                   rec_busy
);
  ////////////////////////////////////////////////////////////////////////////
  // combined channel error: own faults or a fault on the shared supply
  function automatic logic [NUM_CH-1:0] grp_expand(input logic [3:0] g);
    logic [NUM_CH-1:0] r;
    r = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      r[i] = g[i / ivsd_pkg::GRP_SIZE];
    end
    return r;
  endfunction

  logic [NUM_CH-1:0] supply_err;
  logic [NUM_CH-1:0] ch_err;
  assign supply_err = grp_expand(flt_supply);
  assign ch_err = flt_wire_break | flt_short | flt_flutter | flt_changeover
                  | supply_err | {NUM_CH{flt_no_power}};

  ////////////////////////////////////////////////////////////////////////////
  // process image: value and validity captured together
  logic [NUM_CH-1:0] in_word_reg;
  logic [NUM_CH-1:0] stat_word_reg;
  logic [NUM_CH-1:0] err_word_reg;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      in_word_reg   <= '0;
      stat_word_reg <= '0;
    end else if (sample_en) begin
      in_word_reg   <= din_value;
      stat_word_reg <= ~ch_err;             // bit i pairs with input bit i
    end
  end

  // error bits tracked every cycle, 1 while present
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      err_word_reg <= '0;
    end else begin
      err_word_reg <= ch_err;
    end
  end

  // image read: word x is input, x+2 is status
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      img_data  <= 16'h0000;
      img_valid <= 1'b0;
    end else begin
      img_valid <= img_rd;
      if (img_rd) begin
        if (img_addr == ivsd_pkg::ADDR_INPUT_WORD + ivsd_pkg::ADDR_STATUS_OFS) begin
          img_data <= 16'(stat_word_reg);
        end else if (img_addr == ivsd_pkg::ADDR_INPUT_WORD) begin
          img_data <= 16'(in_word_reg);
        end else begin
          img_data <= 16'h0000;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // record image: header bytes 0..3, channel error bytes 4..5, group supply byte 6, power byte 7
  logic       any_ch;
  logic [7:0] hdr0;
  logic [7:0] rec_byte [ivsd_pkg::REC1_LEN];
  logic [2:0] wr_idx_reg;

  assign any_ch = |err_word_reg;
  // common header byte 0, same layout for every module type
  always_comb begin
    hdr0 = 8'h00;
    hdr0[ivsd_pkg::HDR_MOD_FAULT] = any_ch | flt_internal | flt_no_power;
    hdr0[ivsd_pkg::HDR_INT_FAULT] = flt_internal;
    hdr0[ivsd_pkg::HDR_EXT_FAULT] = any_ch;
    hdr0[ivsd_pkg::HDR_CH_FAULT]  = any_ch;
    hdr0[ivsd_pkg::HDR_NO_PWR]    = flt_no_power;
  end

  always_comb begin
    rec_byte[0] = hdr0;
    rec_byte[1] = ivsd_pkg::HDR_CLASS_DI;
    rec_byte[2] = ivsd_pkg::HDR_BYTE2_RST;
    rec_byte[3] = ivsd_pkg::HDR_BYTE3_RST;
    rec_byte[4] = err_word_reg[7:0];         // module-specific channel errors
    rec_byte[5] = err_word_reg[15:8];
    rec_byte[6] = {4'h0, flt_supply};
    rec_byte[7] = {7'h00, flt_no_power};
  end

  // refresh memory continuously, one byte per cycle
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wr_idx_reg <= 3'h0;
    end else begin
      wr_idx_reg <= wr_idx_reg + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // record read sequencer
  ivsd_pkg::ivsd_state_t state_reg;
  logic [2:0] rd_idx_reg;
  logic [2:0] last_idx_reg;
  logic       fetch_reg;
  logic [7:0] mem_q;

  ivsd_rec_mem #(.DEPTH(ivsd_pkg::REC1_LEN)) u_mem (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .wr_en   (1'b1),
    .wr_addr (wr_idx_reg),
    .wr_data (rec_byte[wr_idx_reg]),
    .rd_addr (rd_idx_reg),
    .rd_data (mem_q)
  );

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg    <= ivsd_pkg::IVSD_IDLE;
      rd_idx_reg   <= 3'h0;
      last_idx_reg <= 3'h0;
      fetch_reg    <= 1'b0;
      rec_busy     <= 1'b0;
    end else begin
      case (state_reg)
        ivsd_pkg::IVSD_IDLE: begin
          fetch_reg <= 1'b0;
          if (rec_start) begin
            rd_idx_reg   <= 3'h0;
            last_idx_reg <= (rec_sel == ivsd_pkg::REC_SEL_0) ? 3'(ivsd_pkg::REC0_LEN - 1)
                                                           : 3'(ivsd_pkg::REC1_LEN - 1);
            fetch_reg    <= 1'b1;
            rec_busy     <= 1'b1;
            state_reg    <= ivsd_pkg::IVSD_SEND;
          end
        end
        ivsd_pkg::IVSD_SEND: begin
          if (rd_idx_reg == last_idx_reg) begin
            fetch_reg <= 1'b0;
            state_reg <= ivsd_pkg::IVSD_DONE;
          end else begin
            rd_idx_reg <= rd_idx_reg + 3'h1;
          end
        end
        ivsd_pkg::IVSD_DONE: begin
          rec_busy  <= 1'b0;
          state_reg <= ivsd_pkg::IVSD_IDLE;
        end
        default: begin
          state_reg <= ivsd_pkg::IVSD_IDLE;
        end
      endcase
    end
  end

  // byte output, memory read has one cycle latency
  logic [2:0] out_idx_reg;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rec_valid   <= 1'b0;
      rec_last    <= 1'b0;
      out_idx_reg <= 3'h0;
    end else begin
      rec_valid   <= fetch_reg && state_reg == ivsd_pkg::IVSD_SEND;
      rec_last    <= fetch_reg && state_reg == ivsd_pkg::IVSD_SEND
                     && rd_idx_reg == last_idx_reg;
      out_idx_reg <= rd_idx_reg;
    end
  end
  assign rec_data = mem_q;  // memory output is itself a register

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_valid_low_err: assert property (@(posedge clk_sys) disable iff (sys_rst)
    sample_en |=> stat_word_reg == ~$past(ch_err))
    else $error("validity not cleared on fault");
  a_pair_update: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !sample_en |=> $stable(in_word_reg) && $stable(stat_word_reg))
    else $error("value and status not updated together");
  a_status_addr: assert property (@(posedge clk_sys) disable iff (sys_rst)
    img_rd && img_addr == 8'h02 |=> img_valid && img_data == $past(stat_word_reg))
    else $error("status word not at x+2");
  a_valid_one: assert property (@(posedge clk_sys) disable iff (sys_rst)
    sample_en && ch_err == '0 |=> stat_word_reg == '1)
    else $error("clean channel not valid");
  a_group_err: assert property (@(posedge clk_sys) disable iff (sys_rst)
    flt_supply[2] |=> err_word_reg[11:8] == 4'hF)
    else $error("group fault not spread");
  a_err_level: assert property (@(posedge clk_sys) disable iff (sys_rst)
    flt_flutter != '0 |=> (err_word_reg & $past(flt_flutter)) == $past(flt_flutter))
    else $error("error bit not set");
  a_rec0_len: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state_reg == ivsd_pkg::IVSD_IDLE && rec_start && rec_sel == 2'h0
    |=> ##4 rec_last)
    else $error("record 0 not four bytes");
  a_rec1_len: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state_reg == ivsd_pkg::IVSD_IDLE && rec_start && rec_sel == 2'h1
    |=> ##8 rec_last)
    else $error("record 1 not eight bytes");
  a_hdr_common: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rec_valid && out_idx_reg == 3'h1 |-> rec_data == ivsd_pkg::HDR_CLASS_DI)
    else $error("header class byte wrong");
  a_pos_match: assert property (@(posedge clk_sys) disable iff (sys_rst)
    sample_en && ch_err == 16'h0002 |=> stat_word_reg == 16'hFFFD)
    else $error("validity bit position wrong");
endmodule
`default_nettype wire

//--- ivsd_host.sv
`timescale 1ns/100ps
`default_nettype none
// backplane controller model: reads the process image and the diagnostic records
module ivsd_host (
  // clock
  input  wire logic        clk_sys,
  // process image port
  output logic             img_rd,
  output logic [7:0]       img_addr,
  input  wire logic [15:0] img_data,
  input  wire logic        img_valid,
  // record port
  output logic             rec_start,
  output logic [1:0]       rec_sel,
  input  wire logic [7:0]  rec_data,
  input  wire logic        rec_valid,
  input  wire logic        rec_last,
  input  wire logic        rec_busy
);
  logic [7:0] rec_buf [16];
  int         rec_cnt = 0;
  int         host_err = 0;
  // idle bus values at time zero
  initial begin
    img_rd = 1'b0;
    img_addr = 8'h00;
    rec_start = 1'b0;
    rec_sel = 2'h0;
  end
  ////////////////////////////////////////////////////////////////
  // one image read; address is scrambled once the request is taken
  task automatic read_img(input logic [7:0] a, output logic [15:0] d);
    int n;
    @(negedge clk_sys);
    img_rd = 1'b1;
    img_addr = a;
    @(negedge clk_sys);
    img_rd = 1'b0;
    img_addr = ~a;
    n = 0;
    while (img_valid !== 1'b1 && n < 8) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 8) host_err++;
    d = img_data;
  endtask
  // one record read, bytes gathered into rec_buf
  task automatic read_rec(input logic [1:0] s);
    int n;
    @(negedge clk_sys);
    rec_start = 1'b1;
    rec_sel = s;
    @(negedge clk_sys);
    rec_start = 1'b0;
    rec_sel = ~s;
    rec_cnt = 0;
    for (n = 0; n < 20; n++) begin
      if (rec_valid === 1'b1 && rec_cnt < 16) begin
        rec_buf[rec_cnt] = rec_data;
        rec_cnt++;
      end
      if (rec_last === 1'b1) break;
      @(negedge clk_sys);
    end
    if (n == 20) host_err++;
    for (n = 0; n < 8 && rec_busy !== 1'b0; n++) @(negedge clk_sys);
    if (n == 8) host_err++;
  endtask
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic [15:0] din_value = 16'h0000;
  logic [15:0] flt_wire_break = 16'h0000;
  logic [15:0] flt_short = 16'h0000;
  logic [15:0] flt_flutter = 16'h0000;
  logic [15:0] flt_changeover = 16'h0000;
  logic [3:0]  flt_supply = 4'h0;
  logic        flt_internal = 1'b0;
  logic        flt_no_power = 1'b0;
  logic        sample_en = 1'b0;
  logic        img_rd, img_valid, rec_start, rec_valid, rec_last, rec_busy;
  logic [7:0]  img_addr, rec_data;
  logic [1:0]  rec_sel;
  logic [15:0] img_data, rd;
  int          fails = 0;
  int          check_count = 0;
  // system clock, 8 ns period
  always #4 clk_sys = ~clk_sys;
  ivsd_top dut (.clk_sys, .sys_rst, .din_value, .flt_wire_break, .flt_short, .flt_flutter,
    .flt_changeover, .flt_supply, .flt_internal, .flt_no_power, .sample_en, .img_rd,
    .img_addr, .img_data, .img_valid, .rec_start, .rec_sel, .rec_data, .rec_valid,
    .rec_last, .rec_busy);
  ivsd_host host (.clk_sys, .img_rd, .img_addr, .img_data, .img_valid, .rec_start,
    .rec_sel, .rec_data, .rec_valid, .rec_last, .rec_busy);
  ////////////////////////////////////////////////////////////////
  // compare, count, report
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (fails == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // a hung controller transfer ends the run
  task automatic guard;
    if (host.host_err != 0) begin
      fails++;
      end_of_test();
    end
  endtask
  task automatic img(input logic [7:0] a);
    host.read_img(a, rd);
    guard();
  endtask
  task automatic rec(input logic [1:0] s);
    host.read_rec(s);
    guard();
  endtask
  // one image update, then time for the record memory to refresh
  task automatic sample;
    @(negedge clk_sys);
    sample_en = 1'b1;
    @(negedge clk_sys);
    sample_en = 1'b0;
    repeat (12) @(negedge clk_sys);
  endtask
  ////////////////////////////////////////////////////////////////
  // clean inputs: value word, status word, unmapped word
  task automatic t_image;
    din_value = 16'hA5C3;
    sample();
    img(8'h00);
    check(rd, 16'hA5C3);
    img(8'h02);
    check(rd, 16'hFFFF);
    img(8'h04);
    check(rd, 16'h0000);
  endtask
  // each fault kind on its own channel, value changing in the same update
  task automatic t_kinds;
    logic [15:0] m;
    for (int k = 0; k < 4; k++) begin
      m = 16'h0001 << (k * 4 + 1);
      din_value = ~din_value;
      {flt_wire_break, flt_short, flt_flutter, flt_changeover} = {m, 48'h0} >> (k * 16);
      sample();
      img(8'h00);
      check(rd, din_value);
      img(8'h02);
      check(rd, ~m);
      rec(2'h1);
      check({host.rec_buf[5], host.rec_buf[4]}, m);
    end
    {flt_wire_break, flt_short, flt_flutter, flt_changeover} = 64'h0;
  endtask
  // supply fault of group 2, both records, then recovery
  task automatic t_supply;
    logic [7:0] hdr [4];
    flt_supply = 4'h4;
    sample();
    img(8'h02);
    check(rd, 16'hF0FF);
    rec(2'h1);
    check(16'(host.rec_cnt), 16'h0008);
    check({host.rec_buf[5], host.rec_buf[4]}, 16'h0F00);
    check({host.rec_buf[7], host.rec_buf[6]}, 16'h0004);
    check({8'h00, host.rec_buf[0] & 8'h08}, 16'h0008);
    check({host.rec_buf[2], host.rec_buf[1]}, 16'h000F);
    check({8'h00, host.rec_buf[3]}, 16'h0000);
    for (int i = 0; i < 4; i++) hdr[i] = host.rec_buf[i];
    rec(2'h0);
    check(16'(host.rec_cnt), 16'h0004);
    for (int i = 0; i < 4; i++) check({8'h00, host.rec_buf[i]}, {8'h00, hdr[i]});
    flt_supply = 4'h0;
    sample();
    rec(2'h1);
    check({host.rec_buf[5], host.rec_buf[4]}, 16'h0000);
    check({8'h00, host.rec_buf[0]}, 16'h0000);
  endtask
  // internal fault and lost power
  task automatic t_power;
    flt_internal = 1'b1;
    flt_no_power = 1'b1;
    sample();
    img(8'h02);
    check(rd, 16'h0000);
    rec(2'h1);
    check({8'h00, host.rec_buf[0] & 8'h12}, 16'h0012);
    check({8'h00, host.rec_buf[7]}, 16'h0001);
    rec(2'h2);
    check(16'(host.rec_cnt), 16'h0008);
  endtask
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (2) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (10) @(negedge clk_sys);
    t_image();
    t_kinds();
    t_supply();
    t_power();
    end_of_test();
  end
endmodule
`default_nettype wire
